/* verilog/txcs_pkg.sv */
/*
 * Constants, register map and event type for the transmit control and
 * status register block.
 * Assumes a 200 MHz core clock and a 32-bit APB register port.
 */
package txcs_pkg;

  // Core clock period and the excessive-deferral time.
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned DEFER_TIME_NS = 3_200_000;
  localparam int unsigned DEFER_CYCLES =
    DEFER_TIME_NS / (CLK_PERIOD_PS / 1000);

  // Register indices and byte addresses.
  localparam logic [7:0] TCR_INDEX = 8'h03;
  localparam logic [7:0] ADDR_TCR = 8'h0C;
  localparam logic [7:0] ADDR_INT_STAT = 8'h10;
  localparam logic [7:0] ADDR_INT_EN = 8'h14;
  localparam logic [7:0] ADDR_INT_CLR = 8'h18;

  // Control register bit positions.
  localparam int BIT_SW_INT = 15;
  localparam int BIT_LC_START = 14;
  localparam int BIT_FCS_INH = 13;
  localparam int BIT_DEF_DIS = 12;
  localparam int BIT_EXC_DEFER = 10;
  localparam int BIT_DEFERRED = 9;
  localparam int BIT_NO_CARRIER = 8;
  localparam int BIT_CARRIER_LOST = 7;
  localparam int BIT_TOO_MANY_COL = 6;
  localparam int BIT_LATE_COL = 5;
  localparam int BIT_MON_BAD = 3;
  localparam int BIT_UNDERRUN = 2;
  localparam int BIT_COUNT_MISMATCH = 1;
  localparam int BIT_TX_OK = 0;

  localparam logic [15:0] TCR_RESET = 16'h0101;
  localparam logic [15:0] TCR_WR_MASK = 16'hF000;
  localparam logic [15:0] TCR_RO_ZERO = 16'h0810;
  localparam logic [15:0] START_CLR_MASK = 16'h04C2;
  localparam logic [15:0] WB_CLR_MASK = 16'h0220;

  // Collision limit and status-word collision field.
  localparam logic [4:0] COL_LIMIT = 5'h10;
  localparam int COL_FIELD_LSB = 11;

  // Interrupt status bits.
  localparam int INT_BITS = 3;
  localparam int INT_SW = 0;
  localparam int INT_DONE = 1;
  localparam int INT_ABORT = 2;
  localparam logic [INT_BITS-1:0] INT_RESET = 3'h0;

  // Events from the transmit engine, all on core_clk.
  typedef struct packed {
    logic tx_start;
    logic preamble_go;
    logic sfd_done;
    logic last_byte;
    logic tx_end;
    logic collision;
    logic deferring;
    logic late_col;
    logic monitored_bad;
    logic fifo_underrun;
    logic count_mismatch;
    logic tx_ok;
  } txcs_evt_t;

endpackage : txcs_pkg

/* verilog/txcs_core.sv */
/*
 * Transmit control and status register with its mode latch, status
 * accumulation, deferral and collision limits, descriptor status write-back
 * and an APB register port with a small interrupt unit.
 * Assumes the transmit engine drives txcs_evt_t on core_clk; carrier sense
 * arrives asynchronously from the line side.
 */
// The APB slave port was chosen for this implementation.
// Operation
// - Latch config bits 15..12 at start
// - Set status bits when transmission ends
// - Write status and collisions to descriptor
// - Clear bits 9 and 5 after write-back
// - Clear bits 10,7,6,1 at next start
// - Set bit 8 at next start
// - Hardware reset sets 8,0 clears 1
// - Software reset leaves register unchanged
// - Bits 15..12 writable, 11 and 4 zero
// - Software interrupt after fetching flagged descriptor
// - Further interrupt only after clear then set
// - Late-collision timer start point follows mode bit
// - Append FCS unless inhibit bit set
// - Run deferral timer only when enabled
// - Deferral limit sets flag and aborts
// - Never flag excessive deferral when disabled
// - Sixteen collisions set flag and abort
// - Carrier-absent flag cleared when carrier seen
`timescale 1ns/100ps
module txcs_core
  import txcs_pkg::*;
#(
  parameter int unsigned DEFER_LIMIT = DEFER_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sw_reset,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit engine.
  input wire txcs_evt_t evt,
  input wire logic [15:0] desc_config_word,
  input wire logic carrier_sense,
  output logic fcs_append,
  output logic late_col_timer_go,
  output logic tx_abort,
  // Descriptor status write-back.
  output logic status_valid,
  output logic [15:0] status_word,
  input wire logic status_ack,
  // Interrupts.
  output logic sw_tx_interrupt,
  output logic irq
);

  localparam int DW = $clog2(DEFER_LIMIT + 1);

  logic [15:0] tcr_ff, nxt_tcr;
  logic [10:0] pend_ff, nxt_pend;
  logic [4:0] col_cnt_ff;
  logic [DW-1:0] defer_cnt_ff;
  logic active_ff, crs_win_ff, crs_meta_ff, crs_sync_ff;
  logic abort_ff, lc_go_ff, sw_int_ff, prev_sw_ff;
  logic st_valid_ff;
  logic [15:0] st_word_ff;
  logic [31:0] prdata_ff;
  logic [INT_BITS-1:0] int_stat_ff, int_en_ff;
  logic irq_ff;

  // Register decode.
  wire setup_ph = psel & ~penable;
  wire wr_en = psel & penable & pwrite;
  wire hit_tcr = (paddr == ADDR_TCR);
  wire hit_stat = (paddr == ADDR_INT_STAT);
  wire hit_en = (paddr == ADDR_INT_EN);
  wire hit_clr = (paddr == ADDR_INT_CLR);
  wire hit_any = hit_tcr | hit_stat | hit_en | hit_clr;
  wire wr_tcr = wr_en & hit_tcr;
  wire wr_en_reg = wr_en & hit_en;
  wire wr_clr = wr_en & hit_clr;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  wire [31:0] rd_mux =
    hit_tcr ? {16'h0000, tcr_ff & ~TCR_RO_ZERO} :
    hit_stat ? {29'h0, int_stat_ff} :
    hit_en ? {29'h0, int_en_ff} : 32'h0000_0000;

  // Transmission progress terms.
  wire start = evt.tx_start;
  // An abort ends the frame as well, so its status is still written back.
  wire stop = active_ff & (evt.tx_end | abort_ff);
  wire deferral_timer_disable = tcr_ff[BIT_DEF_DIS];
  wire defer_run = active_ff & evt.deferring & ~deferral_timer_disable;
  wire defer_hit = defer_run &
    (defer_cnt_ff == DW'(DEFER_LIMIT - 1));
  wire [4:0] col_next = col_cnt_ff + 5'h01;
  wire col_hit = active_ff & evt.collision &
    (col_next == COL_LIMIT);
  wire lc_go = active_ff & (tcr_ff[BIT_LC_START] ?
    evt.preamble_go : evt.sfd_done);
  wire sw_rise = tcr_ff[BIT_SW_INT] & ~prev_sw_ff;

  // Status gathered during a frame, committed when it ends.
  always_comb begin
    nxt_pend = pend_ff;
    if (start) begin
      nxt_pend = '0;
    end
    if (defer_hit) begin
      nxt_pend[BIT_EXC_DEFER] = 1'b1;
    end
    if (active_ff & evt.deferring & (col_cnt_ff == 5'h00)) begin
      nxt_pend[BIT_DEFERRED] = 1'b1;
    end
    if (crs_win_ff & ~crs_sync_ff) begin
      nxt_pend[BIT_CARRIER_LOST] = 1'b1;
    end
    if (col_hit) begin
      nxt_pend[BIT_TOO_MANY_COL] = 1'b1;
    end
    if (active_ff) begin
      nxt_pend[BIT_LATE_COL] = pend_ff[BIT_LATE_COL] | evt.late_col;
      nxt_pend[BIT_MON_BAD] = pend_ff[BIT_MON_BAD] | evt.monitored_bad;
      nxt_pend[BIT_UNDERRUN] = pend_ff[BIT_UNDERRUN] | evt.fifo_underrun;
      nxt_pend[BIT_COUNT_MISMATCH] =
        pend_ff[BIT_COUNT_MISMATCH] | evt.count_mismatch;
      nxt_pend[BIT_TX_OK] = pend_ff[BIT_TX_OK] | evt.tx_ok;
    end
  end

  // Control register next value. Bits not named below hold.
  always_comb begin
    nxt_tcr = tcr_ff;
    if (wr_tcr) begin
      nxt_tcr = (tcr_ff & ~TCR_WR_MASK) | (pwdata[15:0] & TCR_WR_MASK);
    end
    if (status_valid & status_ack) begin
      nxt_tcr = nxt_tcr & ~WB_CLR_MASK;
    end
    if (start) begin
      nxt_tcr = (nxt_tcr & ~TCR_WR_MASK & ~START_CLR_MASK) |
        (desc_config_word & TCR_WR_MASK);
      nxt_tcr[BIT_NO_CARRIER] = 1'b1;
    end
    if (crs_win_ff & crs_sync_ff) begin
      nxt_tcr[BIT_NO_CARRIER] = 1'b0;
    end
    if (stop) begin
      nxt_tcr[10:0] = nxt_tcr[10:0] | nxt_pend;
    end
    nxt_tcr = nxt_tcr & ~TCR_RO_ZERO;
  end

  // Carrier sense comes from the line, so it is synchronised first.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      crs_meta_ff <= 1'b0;
      crs_sync_ff <= 1'b0;
    end else begin
      crs_meta_ff <= carrier_sense;
      crs_sync_ff <= crs_meta_ff;
    end
  end

  // The control register ignores sw_reset entirely.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tcr_ff <= TCR_RESET;
      prev_sw_ff <= 1'b0;
    end else begin
      tcr_ff <= nxt_tcr;
      prev_sw_ff <= tcr_ff[BIT_SW_INT];
    end
  end

  // Frame tracking; a software reset abandons a frame in flight.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_ff <= 1'b0;
      crs_win_ff <= 1'b0;
      pend_ff <= '0;
      col_cnt_ff <= 5'h00;
      defer_cnt_ff <= '0;
    end else if (sw_reset) begin
      active_ff <= 1'b0;
      crs_win_ff <= 1'b0;
      pend_ff <= '0;
      col_cnt_ff <= 5'h00;
      defer_cnt_ff <= '0;
    end else begin
      active_ff <= start | (active_ff & ~evt.tx_end & ~abort_ff);
      // The carrier window closes on an abort too, or a stale window
      // would clear the carrier-absent bit of the next frame.
      crs_win_ff <= (crs_win_ff | (active_ff & evt.sfd_done)) &
        ~evt.last_byte & ~evt.tx_end & ~abort_ff;
      pend_ff <= nxt_pend;
      if (start) begin
        col_cnt_ff <= 5'h00;
      end else if (active_ff & evt.collision & ~col_hit) begin
        col_cnt_ff <= col_next;
      end else if (col_hit) begin
        col_cnt_ff <= COL_LIMIT;
      end
      if (defer_run & ~defer_hit) begin
        defer_cnt_ff <= defer_cnt_ff + DW'(1);
      end else begin
        defer_cnt_ff <= '0;
      end
    end
  end

  // Pulses towards the engine and the interrupt logic.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      abort_ff <= 1'b0;
      lc_go_ff <= 1'b0;
      sw_int_ff <= 1'b0;
    end else begin
      abort_ff <= defer_hit | col_hit;
      lc_go_ff <= lc_go;
      sw_int_ff <= sw_rise;
    end
  end

  // Descriptor status write-back, held until the DMA acknowledges it.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_valid_ff <= 1'b0;
      st_word_ff <= 16'h0000;
    end else if (stop) begin
      st_valid_ff <= 1'b1;
      st_word_ff <= {col_cnt_ff, nxt_tcr[10:0]};
    end else if (st_valid_ff & status_ack) begin
      st_valid_ff <= 1'b0;
    end
  end

  // Interrupt unit: a new event wins over a clear in the same cycle.
  wire [INT_BITS-1:0] int_evt = {abort_ff, stop, sw_int_ff};
  wire [INT_BITS-1:0] int_clr = wr_clr ? pwdata[INT_BITS-1:0] : '0;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_stat_ff <= INT_RESET;
      int_en_ff <= INT_RESET;
      irq_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      int_stat_ff <= (int_stat_ff & ~int_clr) | int_evt;
      if (wr_en_reg) begin
        int_en_ff <= pwdata[INT_BITS-1:0];
      end
      irq_ff <= |(int_stat_ff & int_en_ff);
      if (setup_ph) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  assign prdata = prdata_ff;
  assign fcs_append = ~tcr_ff[BIT_FCS_INH];
  assign late_col_timer_go = lc_go_ff;
  assign tx_abort = abort_ff;
  assign status_valid = st_valid_ff;
  assign status_word = st_word_ff;
  assign sw_tx_interrupt = sw_int_ff;
  assign irq = irq_ff;

  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_mode_latch: assert property (
    start |=> tcr_ff[15:12] == $past(desc_config_word[15:12]))
    else $error("mode bits not latched at start");
  a_start_clear: assert property (
    start && !stop |=> (tcr_ff & START_CLR_MASK) == 16'h0000)
    else $error("bits 10,7,6,1 not cleared at start");
  a_start_carrier_absent: assert property (
    start && !(crs_win_ff && crs_sync_ff) |=> tcr_ff[BIT_NO_CARRIER])
    else $error("carrier-absent not set at start");
  a_wb_clear: assert property (
    status_valid && status_ack && !stop |=> (tcr_ff & WB_CLR_MASK) == 0)
    else $error("bits 9 and 5 not cleared after write-back");
  a_zero_bits: assert property (
    (tcr_ff & TCR_RO_ZERO) == 16'h0000)
    else $error("bits 11 or 4 read non-zero");
  a_exd_gated: assert property (
    $rose(pend_ff[BIT_EXC_DEFER]) |-> !$past(tcr_ff[BIT_DEF_DIS]))
    else $error("excessive deferral set while timer disabled");
  a_col_abort: assert property (
    col_hit |=> tx_abort && pend_ff[BIT_TOO_MANY_COL])
    else $error("sixteenth collision did not abort");
  a_sw_int_once: assert property (
    sw_tx_interrupt |=> !sw_tx_interrupt)
    else $error("software interrupt repeated without re-arm");
  a_sw_int_cause: assert property (
    sw_tx_interrupt |-> $past(tcr_ff[BIT_SW_INT]) &&
      !$past(prev_sw_ff))
    else $error("software interrupt without fresh request bit");
  a_lc_start: assert property (
    active_ff && evt.sfd_done && !tcr_ff[BIT_LC_START] |=>
      late_col_timer_go)
    else $error("late-collision timer not started after delimiter");
  a_fcs_mode: assert property (
    start && !desc_config_word[BIT_FCS_INH] && !wr_tcr |=> fcs_append)
    else $error("fcs not appended with inhibit clear");
  a_status_hold: assert property (
    status_valid && !status_ack |=> status_valid && $stable(status_word))
    else $error("status word changed before acknowledge");
  a_defer_abort: assert property (
    defer_hit && !sw_reset |=> tx_abort && pend_ff[BIT_EXC_DEFER])
    else $error("deferral limit did not abort");
  a_abort_commit: assert property (
    tx_abort && active_ff && !status_ack |=> status_valid)
    else $error("aborted frame status not written back");
  a_carrier_absent_clear: assert property (
    crs_win_ff && crs_sync_ff |=> !tcr_ff[BIT_NO_CARRIER])
    else $error("carrier-absent not cleared when carrier seen");
  a_wb_release: assert property (
    status_valid && status_ack && !stop |=> !status_valid)
    else $error("write-back request not released after acknowledge");
  a_lc_preamble: assert property (
    active_ff && evt.preamble_go && tcr_ff[BIT_LC_START] |=>
      late_col_timer_go)
    else $error("late-collision timer not started after preamble");
  a_status_stable: assert property (
    !start && !stop && !(status_valid && status_ack) &&
      !(crs_win_ff && crs_sync_ff) |=> $stable(tcr_ff[10:0]))
    else $error("status bits changed outside set and clear events");

  c_sw_int: cover property (start ##[1:4] sw_tx_interrupt);
  c_col_abort: cover property (col_hit ##1 tx_abort);
  c_writeback: cover property (stop ##[1:20] (status_valid && status_ack));
  c_defer_abort: cover property (defer_hit ##1 tx_abort);
  c_carrier_absent_clear: cover property (start ##[1:40] (crs_win_ff && crs_sync_ff));

endmodule : txcs_core

/* sim/transmit_control_status_reg_bench.sv */
/*
 * Self-checking bench for the transmit control and status register block.
 * Assumes txcs_core and txcs_pkg are compiled first; the bench drives every
 * port itself and shortens the deferral limit to 20 cycles.
 */
`timescale 1ns/100ps
module transmit_control_status_reg_bench;
  import txcs_pkg::*;
  localparam txcs_evt_t E_START = 12'h800;
  localparam txcs_evt_t E_PRE = 12'h400;
  localparam txcs_evt_t E_SFD = 12'h200;
  localparam txcs_evt_t E_LAST = 12'h100;
  localparam txcs_evt_t E_END = 12'h080;
  localparam txcs_evt_t E_COL = 12'h040;
  localparam txcs_evt_t E_DEFER = 12'h020;
  localparam txcs_evt_t E_LATE = 12'h010;
  localparam txcs_evt_t E_OK = 12'h001;
  logic core_clk, reset_n, sw_reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  txcs_evt_t evt;
  logic [15:0] desc_config_word, status_word;
  logic carrier_sense, fcs_append, late_col_timer_go, tx_abort, err;
  logic status_valid, status_ack, sw_tx_interrupt, irq;
  int n_fail, checked, cycles, n_lc, n_abort, n_sw, base;

  txcs_core #(.DEFER_LIMIT(20)) i_dut (.core_clk(core_clk),
    .reset_n(reset_n), .sw_reset(sw_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt(evt),
    .desc_config_word(desc_config_word), .carrier_sense(carrier_sense),
    .fcs_append(fcs_append), .late_col_timer_go(late_col_timer_go),
    .tx_abort(tx_abort), .status_valid(status_valid),
    .status_word(status_word), .status_ack(status_ack),
    .sw_tx_interrupt(sw_tx_interrupt), .irq(irq));

  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Pulses are counted at the falling edge, where they have settled, so a
  // count never races a check made just after a rising edge.
  always @(negedge core_clk) begin
    cycles++;
    if (late_col_timer_go === 1'b1) n_lc++;
    if (tx_abort === 1'b1) n_abort++;
    if (sw_tx_interrupt === 1'b1) n_sw++;
    if (cycles == 4000) begin
      n_fail++;
      end_of_test();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Every task that waits starts just after a rising edge and ends just after a later one.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task ev(input txcs_evt_t e, input int n);
    evt <= e;
    repeat (n) @(posedge core_clk);
    evt <= '0;
    @(posedge core_clk);
  endtask : ev

  task start(input logic [15:0] cfg);
    desc_config_word <= cfg;
    ev(E_START, 1);
  endtask : start

  task ack;
    status_ack <= 1'b1;
    @(posedge core_clk);
    status_ack <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : ack

  task t_regs;
    apb(1'b0, ADDR_TCR, 32'h0);
    chk(rd, 32'h0000_0101);
    chk(fcs_append, 1'b1);
    apb(1'b1, ADDR_TCR, 32'hFFFF_FFFF);
    apb(1'b0, ADDR_TCR, 32'h0);
    chk(rd, 32'h0000_F101);
    chk(fcs_append, 1'b0);
    apb(1'b1, ADDR_TCR, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("register access test done");
  endtask : t_regs

  task t_frame_ok;
    base = n_sw;
    start(16'h8000);
    ev(E_PRE, 1);
    ev(E_SFD, 1);
    chk(n_lc, 1);
    ev(E_DEFER, 2);
    ev(E_LATE, 1);
    ev(E_OK, 1);
    ev(E_LAST, 1);
    ev(E_END, 1);
    chk(n_sw - base, 1);
    chk({status_valid, status_word}, 32'h1_03A1);
    apb(1'b0, ADDR_TCR, 32'h0);
    chk(rd, 32'h0000_83A1);
    ack();
    apb(1'b0, ADDR_TCR, 32'h0);
    chk({status_valid, rd[15:0]}, 32'h0_8181);
    $display("good frame test done");
  endtask : t_frame_ok

  task t_frame_col;
    base = n_sw;
    carrier_sense <= 1'b1;
    start(16'h7000);
    apb(1'b0, ADDR_TCR, 32'h0);
    chk(rd, 32'h0000_7101);
    chk(fcs_append, 1'b0);
    ev(E_PRE, 1);
    chk(n_lc, 2);
    ev(E_SFD, 1);
    ev(E_DEFER, 25);
    chk(n_abort, 0);
    chk(n_lc, 2);
    for (int i = 0; i < 16; i++) ev(E_COL, 1);
    chk(n_abort, 1);
    @(posedge core_clk);
    chk({status_valid, status_word}, 32'h1_8241);
    ack();
    apb(1'b0, ADDR_TCR, 32'h0);
    chk(rd, 32'h0000_7041);
    chk(n_sw - base, 0);
    $display("collision frame test done");
  endtask : t_frame_col

  task t_frame_defer;
    base = n_sw;
    carrier_sense <= 1'b0;
    start(16'h8000);
    ev(E_DEFER, 22);
    chk(n_abort, 2);
    chk(n_sw - base, 1);
    chk(status_word, 16'h0701);
    ack();
    start(16'h8000);
    sw_reset <= 1'b1;
    @(posedge core_clk);
    sw_reset <= 1'b0;
    apb(1'b0, ADDR_TCR, 32'h0);
    chk(rd, 32'h0000_8101);
    chk(n_sw - base, 1);
    $display("deferral frame test done");
  endtask : t_frame_defer

  task t_irq;
    apb(1'b1, ADDR_INT_STAT, 32'h0);
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    chk(rd, 32'h7);
    chk(irq, 1'b0);
    apb(1'b1, ADDR_INT_EN, 32'h2);
    @(posedge core_clk);
    chk(irq, 1'b1);
    apb(1'b1, ADDR_INT_EN, 32'h0);
    @(posedge core_clk);
    chk(irq, 1'b0);
    apb(1'b1, ADDR_INT_EN, 32'h7);
    apb(1'b1, ADDR_INT_CLR, 32'h7);
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    chk({rd[30:0], irq}, 32'h0);
    $display("interrupt test done");
  endtask : t_irq

  initial begin
    {reset_n, sw_reset, psel, penable, pwrite, status_ack} = '0;
    {paddr, pwdata, desc_config_word, carrier_sense} = '0;
    evt = '0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_frame_ok();
    t_frame_col();
    t_frame_defer();
    t_irq();
    end_of_test();
  end
endmodule : transmit_control_status_reg_bench
